//--- rtl/adc_seq_pkg.sv
// Shared constants and types of the converter sequencer
package adc_seq_pkg;
   // Clock and times
   localparam int CLK_PERIOD_NS = 100;
   localparam int CONV_TIME_NS = 3300;
   localparam int TEMP_TIME_NS = 53100;
   localparam int EXT_REF_WAKE_NS = 10000;

   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cycles

   localparam logic [15:0] CONV_CYCLES = 16'(ns_to_cycles(CONV_TIME_NS));
   localparam logic [15:0] TEMP_CYCLES = 16'(ns_to_cycles(TEMP_TIME_NS));
   localparam logic [15:0] EXT_REF_WAKE_CYCLES = 16'(ns_to_cycles(EXT_REF_WAKE_NS));

   // Clock modes
   localparam logic [1:0] CKMODE_INT_TRIG = 2'h0;
   localparam logic [1:0] CKMODE_EXT_ACQ = 2'h1;
   localparam logic [1:0] CKMODE_INT_SERIAL = 2'h2;
   localparam logic [1:0] CKMODE_EXT_CLOCK = 2'h3;
   localparam logic [1:0] CKMODE_RESET = CKMODE_INT_SERIAL;

   // Reference modes and scan modes
   localparam logic [1:0] REF_INT_POWERED = 2'h0;
   localparam logic [1:0] REF_EXTERNAL = 2'h1;
   localparam logic [1:0] REF_RESET = REF_INT_POWERED;
   localparam logic [1:0] SCAN_REPEAT = 2'h2;
   localparam logic [1:0] SCAN_RESET = 2'h0;

   // Command byte layout
   localparam int CONV_FLAG_BIT = 7;
   localparam int CONV_CHAN_MSB = 6;
   localparam int CONV_CHAN_LSB = 3;
   localparam int CONV_SCAN_MSB = 2;
   localparam int CONV_SCAN_LSB = 1;
   localparam int CONV_TEMP_BIT = 0;
   localparam logic [1:0] SETUP_PATTERN = 2'h1;
   localparam int SETUP_CK_MSB = 5;
   localparam int SETUP_CK_LSB = 4;
   localparam int SETUP_REF_MSB = 3;
   localparam int SETUP_REF_LSB = 2;
   localparam logic [3:0] RESET_PATTERN = 4'h1;
   localparam int RESET_BIAS_BIT = 3;
   localparam logic [7:0] NOP_BYTE = 8'h00;

   // Result stream
   localparam int FIFO_DEPTH = 17;
   localparam int RESULT_W = 16;
   localparam logic [3:0] LEADING_ZEROS = 4'h0;
   localparam logic [4:0] NOP_POWER_DOWN = 5'h02;
   localparam logic [4:0] TEMP_LOAD_BYTES = 5'h16;
   localparam logic [4:0] TEMP_TOTAL_BYTES = 5'h18;

   // Synchronised serial link events
   typedef struct packed {
      logic sclkRise;
      logic sclkFall;
      logic csLow;
      logic csFall;
      logic csRise;
      logic din;
   } link_t;
endpackage : adc_seq_pkg

//--- rtl/adc_serial_conversion_sequencer.sv
// Serial-started conversion sequencer with result store and DAC load
// How it works
// [RULE1] In mode 10 a conversion byte runs wake, scan, store and shutdown alone.
// [RULE2] After reset the clock mode is 10 until a setup byte changes it.
// [RULE3] In mode 10 the end flag drops low once all results are stored.
// [RULE4] A requested temperature result is stored ahead of channel results.
// [RULE5] The end flag stays low until chip select next falls.
// [RULE6] Host reads the store only after every conversion has finished.
// [RULE7] DAC and GPIO bytes are still accepted while a scan runs.
// [RULE8] Mode 11 does one conversion per byte, no scan, average or store.
// [RULE9] In mode 11 output data changes on rising serial clock edges.
// [RULE10] Host sends a conversion byte then sixteen clocks in mode 11.
// [RULE11] Host keeps any chip select gap after bit eight below 100 us.
// [RULE12] A zero byte between conversion bytes is the result slot.
// [RULE13] Two zero bytes power the analog down; bias keep bit holds bias.
// [RULE14] Host waits 45 us with chip select high for reference power-up.
// [RULE15] Mode 11 temperature: 24 zero bytes, result in the last two.
// [RULE16] Scan time is sample time times channels times averages times repeats plus extras.
// [RULE17] Load strobe low copies DAC inputs to outputs, transparent if held.
// [RULE18] Results go out as two bytes: four zeros, value, two sub-bits.
// [RULE19] A byte cut short by chip select rising is thrown away.
`timescale 1ns/1ps
module adc_serial_conversion_sequencer
   import adc_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Serial pins
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   output logic dout,
   output logic eocN,
   // Conversion settings
   input wire logic [2:0] avgLog2,
   input wire logic [4:0] scanRepeats,
   // Analog front end
   output logic sampleReq,
   output logic tempSel,
   output logic [3:0] chanSel,
   input wire logic [11:0] adcResult,
   input wire logic [11:0] tempResult,
   output logic analogPowered,
   output logic biasPowered,
   // Other register traffic
   output logic [7:0] otherByte,
   output logic otherByteValid,
   output logic [1:0] clockMode,
   // DAC load
   input wire logic dacLoadStrobeN,
   input wire logic [39:0] dacInput,
   output logic [39:0] dacOutput
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAKE = 4'b0010,
      ST_TEMP = 4'b0100,
      ST_CONV = 4'b1000
   } state_t;

   typedef struct packed {
      state_t st;
      logic [1:0] ckMode;
      logic [1:0] refMode;
      logic biasKeep;
      logic [7:0] inSr;
      logic [2:0] inCnt;
      logic [15:0] outSr;
      logic [3:0] outCnt;
      logic [3:0] lastChan;
      logic [3:0] chan;
      logic [1:0] scanMode;
      logic tempReq;
      logic [15:0] timer;
      logic [5:0] avgCnt;
      logic [4:0] repCnt;
      logic [16:0] accum;
      logic [FIFO_DEPTH-1:0][RESULT_W-1:0] fifo;
      logic [4:0] wrPtr;
      logic [4:0] rdPtr;
      logic eocN;
      logic analogOn;
      logic m11Active;
      logic m11Temp;
      logic [4:0] byteCnt;
      logic sampleReq;
      logic tempSel;
      logic [7:0] otherByte;
      logic otherValid;
   } seq_t;

   link_t link;
   seq_t r;
   seq_t s;
   logic [7:0] rxByte;
   logic byteDone;
   logic [5:0] avgTotal;
   logic [4:0] repTotal;
   logic [16:0] accSum;

   serial_link_rx linkRx (
      .clk(clk),
      .resetn(resetn),
      .sclk(sclk),
      .csN(csN),
      .mosi(mosi),
      .link(link)
   );

   dac_load_latch dacLatch (
      .clk(clk),
      .resetn(resetn),
      .dacLoadStrobeN(dacLoadStrobeN),
      .dacInput(dacInput),
      .dacOutput(dacOutput)
   );

   // Result word: four zeros, ten-bit value, two sub-bits
   function automatic logic [15:0] result_word(input logic [11:0] v);
      return {LEADING_ZEROS, v}; // [RULE18]
   endfunction : result_word

   // Store one result at the write pointer
   function automatic seq_t push(input seq_t x, input logic [15:0] w);
      seq_t y;
      y = x;
      if (x.wrPtr < 5'(FIFO_DEPTH)) begin
         y.fifo[x.wrPtr] = w;
         y.wrPtr = x.wrPtr + 5'h01;
      end
      return y;
   endfunction : push

   // Load the next stored result into the output shifter
   function automatic seq_t pop(input seq_t x);
      seq_t y;
      y = x;
      y.outCnt = 4'h0;
      if (x.rdPtr != x.wrPtr) begin
         y.outSr = x.fifo[x.rdPtr];
         y.rdPtr = x.rdPtr + 5'h01;
      end else begin
         y.outSr = 16'h0000;
      end
      return y;
   endfunction : pop

   assign rxByte = {r.inSr[6:0], link.din};
   assign byteDone = link.sclkRise & link.csLow & (r.inCnt == 3'h7);
   assign avgTotal = 6'h01 << avgLog2;
   assign repTotal = ((r.scanMode == SCAN_REPEAT) && (scanRepeats != 5'h00)) ?
                     scanRepeats : 5'h01;
   assign accSum = r.accum + {5'h00, adcResult};

   always_comb begin
      s = r;
      s.sampleReq = 1'b0;
      s.otherValid = 1'b0;

      // Serial input; a cut-short byte is lost with the counter
      if (link.csRise) begin
         s.inCnt = 3'h0; // [RULE19]
      end else if (link.sclkRise && link.csLow) begin
         s.inSr = rxByte;
         s.inCnt = r.inCnt + 3'h1;
      end

      // Serial output shifting
      if (r.ckMode == CKMODE_EXT_CLOCK) begin
         if (link.sclkRise && link.csLow) begin
            s.outSr = {r.outSr[14:0], 1'b0}; // [RULE9]
         end
      end else begin
         if (link.csFall) begin
            s = pop(s);
         end else if (link.sclkFall && link.csLow) begin
            if (r.outCnt == 4'hF) begin
               s = pop(s);
            end else begin
               s.outSr = {r.outSr[14:0], 1'b0};
               s.outCnt = r.outCnt + 4'h1;
            end
         end
      end

      // End flag released by chip select
      if (link.csFall) begin
         s.eocN = 1'b1; // [RULE5]
      end

      // Internally timed scan
      case (r.st)
         ST_IDLE: begin
         end
         ST_WAKE: begin
            if (r.timer <= 16'h0001) begin
               if (r.tempReq) begin
                  s.st = ST_TEMP;
                  s.timer = TEMP_CYCLES;
                  s.tempSel = 1'b1;
               end else begin
                  s.st = ST_CONV;
                  s.timer = CONV_CYCLES;
               end
               s.sampleReq = 1'b1;
            end else begin
               s.timer = r.timer - 16'h0001;
            end
         end
         ST_TEMP: begin
            if (r.timer <= 16'h0001) begin
               s = push(s, {LEADING_ZEROS, tempResult}); // [RULE4]
               s.tempSel = 1'b0;
               s.st = ST_CONV;
               s.timer = CONV_CYCLES; // [RULE16]
               s.sampleReq = 1'b1;
            end else begin
               s.timer = r.timer - 16'h0001;
            end
         end
         ST_CONV: begin
            if (r.timer > 16'h0001) begin
               s.timer = r.timer - 16'h0001;
            end else begin
               s.timer = CONV_CYCLES;
               s.sampleReq = 1'b1;
               if (r.avgCnt + 6'h01 < avgTotal) begin
                  s.accum = accSum;
                  s.avgCnt = r.avgCnt + 6'h01;
               end else begin
                  s = push(s, result_word(12'(accSum >> avgLog2)));
                  s.accum = 17'h00000;
                  s.avgCnt = 6'h00;
                  if (r.chan < r.lastChan) begin
                     s.chan = r.chan + 4'h1;
                  end else if (r.repCnt + 5'h01 < repTotal) begin
                     s.repCnt = r.repCnt + 5'h01; // [RULE16]
                     s.chan = r.scanMode[0] ? r.lastChan : 4'h0;
                  end else begin
                     s.st = ST_IDLE;
                     s.sampleReq = 1'b0;
                     s.analogOn = 1'b0; // [RULE1]
                     s.eocN = 1'b0; // [RULE3]
                  end
               end
            end
         end
         default: begin
            s.st = ST_IDLE;
         end
      endcase

      // Completed command bytes
      if (byteDone) begin
         if (rxByte[CONV_FLAG_BIT]) begin
            s.lastChan = rxByte[CONV_CHAN_MSB:CONV_CHAN_LSB];
            s.scanMode = rxByte[CONV_SCAN_MSB:CONV_SCAN_LSB];
            s.tempReq = rxByte[CONV_TEMP_BIT];
            if (r.ckMode == CKMODE_EXT_CLOCK) begin
               s.m11Active = 1'b1; // [RULE8]
               s.m11Temp = rxByte[CONV_TEMP_BIT];
               s.byteCnt = 5'h00;
               s.analogOn = 1'b1;
               s.chan = rxByte[CONV_CHAN_MSB:CONV_CHAN_LSB];
               s.tempSel = rxByte[CONV_TEMP_BIT];
               s.sampleReq = 1'b1;
               s.outSr = rxByte[CONV_TEMP_BIT] ? 16'h0000 : result_word(adcResult); // [RULE12]
            end else if (r.ckMode == CKMODE_INT_SERIAL) begin
               s.st = ST_WAKE; // [RULE1]
               s.timer = (r.refMode == REF_EXTERNAL) ? EXT_REF_WAKE_CYCLES : 16'h0001; // [RULE16]
               s.eocN = 1'b1;
               s.analogOn = 1'b1;
               s.wrPtr = 5'h00;
               s.rdPtr = 5'h00;
               s.chan = rxByte[CONV_SCAN_LSB] ? rxByte[CONV_CHAN_MSB:CONV_CHAN_LSB] : 4'h0;
               s.repCnt = 5'h00;
               s.avgCnt = 6'h00;
               s.accum = 17'h00000;
            end
         end else if (rxByte[7:6] == SETUP_PATTERN) begin
            s.ckMode = rxByte[SETUP_CK_MSB:SETUP_CK_LSB];
            s.refMode = rxByte[SETUP_REF_MSB:SETUP_REF_LSB];
         end else if (rxByte[7:4] == RESET_PATTERN) begin
            s.biasKeep = rxByte[RESET_BIAS_BIT]; // [RULE13]
         end else if (rxByte == NOP_BYTE) begin
            if (r.m11Active) begin
               s.byteCnt = r.byteCnt + 5'h01;
               if (r.m11Temp) begin
                  if (r.byteCnt + 5'h01 == TEMP_LOAD_BYTES) begin
                     s.outSr = {LEADING_ZEROS, tempResult}; // [RULE15]
                  end
                  if (r.byteCnt + 5'h01 == TEMP_TOTAL_BYTES) begin
                     s.m11Active = 1'b0;
                     s.analogOn = 1'b0;
                     s.tempSel = 1'b0;
                  end
               end else if (r.byteCnt + 5'h01 == NOP_POWER_DOWN) begin
                  s.m11Active = 1'b0;
                  s.analogOn = 1'b0; // [RULE13]
               end
            end
         end else begin
            s.otherByte = rxByte; // [RULE7]
            s.otherValid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.ckMode <= CKMODE_RESET; // [RULE2]
         r.refMode <= REF_RESET;
         r.scanMode <= SCAN_RESET;
         r.eocN <= 1'b1;
      end else begin
         r <= s;
      end
   end

   assign dout = r.outSr[15];
   assign eocN = r.eocN;
   assign sampleReq = r.sampleReq;
   assign tempSel = r.tempSel;
   assign chanSel = r.chan;
   assign analogPowered = r.analogOn;
   assign biasPowered = r.analogOn | r.biasKeep; // [RULE13]
   assign otherByte = r.otherByte;
   assign otherByteValid = r.otherValid;
   assign clockMode = r.ckMode;
endmodule : adc_serial_conversion_sequencer

//--- rtl/dac_load_latch.sv
// DAC output registers loaded by the load strobe pin
`timescale 1ns/1ps
module dac_load_latch
   import adc_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Strobe pin and data
   input wire logic dacLoadStrobeN,
   input wire logic [39:0] dacInput,
   output logic [39:0] dacOutput
);
   typedef struct packed {
      logic [1:0] strobeSync;
      logic [39:0] outReg;
   } dac_t;

   dac_t dacReg;
   dac_t dacNext;

   always_comb begin
      dacNext = dacReg;
      dacNext.strobeSync = {dacReg.strobeSync[0], dacLoadStrobeN};
      if (!dacReg.strobeSync[1]) begin
         dacNext.outReg = dacInput; // [RULE17]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dacReg <= '{strobeSync: 2'h3, outReg: 40'h0};
      end else begin
         dacReg <= dacNext;
      end
   end

   assign dacOutput = dacReg.outReg;
endmodule : dac_load_latch

//--- rtl/serial_link_rx.sv
// Serial pin synchroniser and edge finder
`timescale 1ns/1ps
module serial_link_rx
   import adc_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Pins
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   // Events
   output link_t link
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic sclkOld;
      logic csOld;
   } rx_t;

   rx_t rxReg;
   rx_t rxNext;

   always_comb begin
      rxNext = rxReg;
      rxNext.meta = {sclk, csN, mosi};
      rxNext.sync = rxReg.meta;
      rxNext.sclkOld = rxReg.sync[2];
      rxNext.csOld = rxReg.sync[1];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxReg <= '{meta: 3'h2, sync: 3'h2, sclkOld: 1'b0, csOld: 1'b1};
      end else begin
         rxReg <= rxNext;
      end
   end

   assign link.sclkRise = rxReg.sync[2] & ~rxReg.sclkOld;
   assign link.sclkFall = ~rxReg.sync[2] & rxReg.sclkOld;
   assign link.csLow = ~rxReg.sync[1];
   assign link.csFall = ~rxReg.sync[1] & rxReg.csOld;
   assign link.csRise = rxReg.sync[1] & ~rxReg.csOld;
   assign link.din = rxReg.sync[0];
endmodule : serial_link_rx

//--- tb/adc_seq_checker_assertions.sv
// Port checker of the conversion sequencer
`timescale 1ns/1ps
module adc_seq_checker
   import adc_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Watched ports
   input wire logic sclk,
   input wire logic csN,
   input wire logic dout,
   input wire logic eocN,
   input wire logic sampleReq,
   input wire logic analogPowered,
   input wire logic biasPowered,
   input wire logic otherByteValid,
   input wire logic [1:0] clockMode,
   input wire logic dacLoadStrobeN,
   input wire logic [39:0] dacInput,
   input wire logic [39:0] dacOutput
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   property p_mode_reset;
      $rose(resetn) |-> clockMode == CKMODE_RESET;
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("mode after reset");
   property p_eoc_mode;
      $fell(eocN) |-> clockMode == CKMODE_INT_SERIAL;
   endproperty
   a_eoc_mode: assert property (p_eoc_mode) else $error("end flag mode");
   property p_eoc_off;
      $fell(eocN) |-> ##[0:2] !analogPowered;
   endproperty
   a_eoc_off: assert property (p_eoc_off) else $error("no shutdown");
   property p_eoc_hold;
      !eocN && csN && $past(csN) |=> !eocN;
   endproperty
   a_eoc_hold: assert property (p_eoc_hold) else $error("end flag lost");
   property p_eoc_clear;
      $fell(csN) && !eocN |-> ##[2:6] eocN;
   endproperty
   a_eoc_clear: assert property (p_eoc_clear) else $error("end flag kept");
   property p_sample_pow;
      sampleReq |-> analogPowered;
   endproperty
   a_sample_pow: assert property (p_sample_pow) else $error("sample unpowered");
   property p_single;
      clockMode == CKMODE_EXT_CLOCK && sampleReq |=> !sampleReq [*8];
   endproperty
   a_single: assert property (p_single) else $error("extra sample");
   property p_rise_out;
      clockMode == CKMODE_EXT_CLOCK && $past(clockMode) == CKMODE_EXT_CLOCK && $changed(dout)
         |-> $past(sclk, 2);
   endproperty
   a_rise_out: assert property (p_rise_out) else $error("output off rise");
   property p_bias;
      analogPowered |-> biasPowered;
   endproperty
   a_bias: assert property (p_bias) else $error("bias off");
   property p_other;
      otherByteValid |=> !otherByteValid;
   endproperty
   a_other: assert property (p_other) else $error("long byte pulse");
   property p_dac_follow;
      (!dacLoadStrobeN && $stable(dacInput)) [*5] |-> dacOutput == dacInput;
   endproperty
   a_dac_follow: assert property (p_dac_follow) else $error("no follow");
   property p_dac_hold;
      dacLoadStrobeN [*5] |-> $stable(dacOutput);
   endproperty
   a_dac_hold: assert property (p_dac_hold) else $error("load unasked");
endmodule : adc_seq_checker
bind adc_serial_conversion_sequencer adc_seq_checker chk (
   .clk(clk),
   .resetn(resetn),
   .sclk(sclk),
   .csN(csN),
   .dout(dout),
   .eocN(eocN),
   .sampleReq(sampleReq),
   .analogPowered(analogPowered),
   .biasPowered(biasPowered),
   .otherByteValid(otherByteValid),
   .clockMode(clockMode),
   .dacLoadStrobeN(dacLoadStrobeN),
   .dacInput(dacInput),
   .dacOutput(dacOutput)
);

//--- tb/adc_serial_conversion_sequencer_test.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module adc_serial_conversion_sequencer_test;
   import adc_seq_pkg::*;
   logic clk, resetn, sclk, csN, mosi, dout, eocN, sampleReq, tempSel, useChan;
   logic analogPowered, biasPowered, otherByteValid, dacLoadStrobeN;
   logic [2:0] avgLog2;
   logic [4:0] scanRepeats;
   logic [3:0] chanSel;
   logic [11:0] adcResult, tempResult, base;
   logic [7:0] otherByte, gotOther, hi, lo, rx;
   logic [1:0] clockMode;
   logic [39:0] dacInput, dacOutput, d;
   logic [39:0] q[$];
   int nMismatch, testsRun, n, e, nSample, s0;

   spi_host_model host (.clk, .sclk, .csN, .mosi, .dout);
   adc_serial_conversion_sequencer DUT (.clk, .resetn, .sclk, .csN, .mosi, .dout, .eocN,
      .avgLog2, .scanRepeats, .sampleReq, .tempSel, .chanSel, .adcResult, .tempResult,
      .analogPowered, .biasPowered, .otherByte, .otherByteValid, .clockMode,
      .dacLoadStrobeN, .dacInput, .dacOutput);

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Front end: scan results differ by channel
   always @(posedge clk) begin
      adcResult <= useChan ? base ^ {8'h00, chanSel} : base;
      if (sampleReq)
         nSample <= nSample + 1;
      if (otherByteValid)
         gotOther <= otherByte;
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      testsRun++;
      if (got !== exp) begin
         nMismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic endOfTest();
      if (nMismatch == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : endOfTest

   task automatic frame(input logic [7:0] b);
      host.selectDev();
      host.xfer(b, 8, rx);
      host.releaseDev(8);
   endtask : frame

   task automatic waitEoc();
      n = 0;
      while (eocN !== 1'b0 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 5000) begin
         nMismatch++;
         $display("[FAIL] %0t end flag timeout", $time);
         endOfTest();
      end
   endtask : waitEoc

   task automatic readWords();
      host.selectDev();
      while (q.size() > 0) begin
         host.xfer(NOP_BYTE, 8, hi);
         host.xfer(NOP_BYTE, 8, lo);
         chk(40'({hi, lo}), q.pop_front());
      end
      host.releaseDev(8);
   endtask : readWords

   // Two back-to-back single conversions, then two zero bytes
   task automatic m11Frame();
      logic [11:0] first;
      first = 12'($urandom);
      base <= first;
      host.selectDev();
      host.xfer(8'h90, 8, rx);
      base <= 12'($urandom);
      host.xfer(NOP_BYTE, 8, hi);
      host.xfer(8'hA8, 8, lo);
      chk(40'({hi, lo}), 40'({4'h0, first}));
      host.xfer(NOP_BYTE, 8, hi);
      host.xfer(NOP_BYTE, 8, lo);
      chk(40'({hi, lo}), 40'({4'h0, base}));
      host.releaseDev(8);
      chk(40'(analogPowered), 40'h0);
   endtask : m11Frame

   initial begin
      resetn = 1'b0;
      avgLog2 = 3'h0;
      scanRepeats = 5'h00;
      adcResult = 12'h000;
      tempResult = 12'h000;
      base = 12'h000;
      useChan = 1'b1;
      gotOther = 8'h00;
      dacLoadStrobeN = 1'b1;
      dacInput = 40'h0;
      void'($urandom(47));
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      host.tick(2);
      chk(40'(clockMode), 40'(CKMODE_RESET));
      // DAC load strobe
      dacInput <= 40'({$urandom, $urandom});
      host.tick(8);
      chk(dacOutput, 40'h0);
      dacLoadStrobeN <= 1'b0;
      host.tick(8);
      chk(dacOutput, dacInput);
      dacInput <= 40'({$urandom, $urandom});
      host.tick(8);
      chk(dacOutput, dacInput);
      d = dacInput;
      dacLoadStrobeN <= 1'b1;
      host.tick(6);
      dacInput <= ~d;
      host.tick(8);
      chk(dacOutput, d);
      // Scan with temperature, averaging and repeats
      avgLog2 <= 3'h1;
      scanRepeats <= 5'h02;
      base <= 12'($urandom);
      tempResult <= 12'($urandom);
      s0 = nSample;
      host.selectDev();
      host.xfer(8'h8D, 8, rx);
      host.releaseDev(0);
      waitEoc();
      e = 1 + int'(TEMP_CYCLES) + int'(CONV_CYCLES) * 8;
      chk(40'(n >= e - 12 && n <= e + 4), 40'h1);
      chk(40'(nSample - s0), 40'(1 + 2 * 2 * 2));
      q.push_back(40'({4'h0, tempResult}));
      for (int r = 0; r < 4; r++)
         q.push_back(40'({4'h0, base ^ 12'(r % 2)}));
      host.tick(20);
      chk(40'(eocN), 40'h0);
      readWords();
      // Externally clocked conversions, bias keep off and on
      useChan <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         frame(k ? 8'h18 : 8'h10);
         frame(8'h74);
         chk(40'(clockMode), 40'(CKMODE_EXT_CLOCK));
         m11Frame();
         chk(40'(biasPowered), 40'(k));
      end
      // Externally clocked temperature
      host.selectDev();
      host.xfer(8'h81, 8, rx);
      chk(40'(tempSel), 40'h1);
      host.releaseDev(450);
      host.selectDev();
      for (int k = 0; k < 24; k++) begin
         hi = lo;
         host.xfer(NOP_BYTE, 8, lo);
      end
      host.releaseDev(8);
      chk(40'({hi, lo}), 40'({4'h0, tempResult}));
      chk(40'({tempSel, analogPowered, biasPowered}), 40'h1);
      // Cut-short setup byte
      host.selectDev();
      host.xfer(8'h44, 4, rx);
      host.releaseDev(8);
      chk(40'(clockMode), 40'(CKMODE_EXT_CLOCK));
      // Other byte while a long scan runs
      frame(8'h64);
      chk(40'(clockMode), 40'(CKMODE_INT_SERIAL));
      avgLog2 <= 3'h5;
      s0 = nSample;
      frame(8'h9A);
      frame(8'h2A);
      waitEoc();
      chk(40'(gotOther), 40'h2A);
      chk(40'(nSample - s0), 40'h20);
      endOfTest();
   end
endmodule : adc_serial_conversion_sequencer_test

//--- tb/spi_host_model.sv
// Serial host model that drives the link pins
`timescale 1ns/1ps
module spi_host_model
   import adc_seq_pkg::*;
(
   // Clock
   input wire logic clk,
   // Link pins
   output logic sclk,
   output logic csN,
   output logic mosi,
   input wire logic dout
);
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      mosi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic selectDev();
      csN <= 1'b0;
      tick(8);
   endtask : selectDev
   // Clock stays low between frames; data shows the inverse of its last bit
   task automatic releaseDev(input int gap);
      csN <= 1'b1;
      mosi <= ~mosi;
      tick(gap);
   endtask : releaseDev
   // MSB first, 4 clk per phase, output read in mid high phase
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         mosi <= tx[i];
         tick(4);
         sclk <= 1'b1;
         tick(2);
         rx[i] = dout;
         tick(2);
         sclk <= 1'b0;
      end
      tick(4);
   endtask : xfer
endmodule : spi_host_model
